// ==== stepper_phase_sequencer.sv ====
// stepper_phase_sequencer: eight-state phase sequencer with fault gating
// assumes pins synchronous to clk_i, Wishbone classic master, 40 MHz clock
//
// Function
// - per bridge phase and enable from state
// - only a step rising edge (step clock pin, or ctrl step bit in software mode) advances state
// - power-up and reset give state 1
// - half select high visits all eight
// - half-step up 1..8, down 1,8..2
// - full select at odd state: normal
// - normal moves two states per step
// - full select at even state: wave
// - wave moves two even states per step
// - odd states two phases, even one
// - overcurrent flag at high-side threshold
// - overcurrent pulls drive-allow line low
// - resume only after drive-allow returns high
// - thermal off at 165, on after 15 cooling
`timescale 1ns/1ps
module stepper_phase_sequencer
   import stepper_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic step_clock_i,
   input wire logic rotation_direction_i,
   input wire logic half_select_i,
   input wire logic seq_reset_i,
   input wire logic overcurrent_detector_i,
   input wire logic [7:0] die_temp_i,
   input wire logic drive_allow_i,
   output logic drive_allow_o,
   output logic drive_allow_oe_o,
   output logic phase_a_o,
   output logic enable_a_o,
   output logic phase_b_o,
   output logic enable_b_o,
   output logic irq_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   // ----------------------------------------------------------------------
   // state record
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [2:0] state;
      logic step_prev;
      logic soft_step_prev;
      logic [4:0] ctrl;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic ocd_latched;
      logic therm_off;
      logic [15:0] step_count;
      bus_state_type bus;
      logic [31:0] dat;
      logic ack;
      logic pull_low;
      logic phase_a;
      logic enable_a;
      logic phase_b;
      logic enable_b;
      logic irq;
   } seq_type;

   seq_type r;
   seq_type next_r;
   phase_if pif();

   // ----------------------------------------------------------------------
   // phase table
   // ----------------------------------------------------------------------
   assign pif.state = r.state;

   phase_lut lut_inst (
      .port_i(pif.lut)
   );

   // next sequencer state for one step
   function automatic logic [2:0] step_next(input logic [2:0] cur, input logic half,
                                            input logic dir);
      logic [2:0] inc;
      inc = (half) ? 3'h1 : 3'h2;
      if (dir) begin
         step_next = cur + inc;
      end else begin
         step_next = cur - inc;
      end
   endfunction

   // read mux, shared decode
   function automatic logic [31:0] read_word(input seq_type s, input logic [7:0] adr);
      read_word = 32'h0000_0000;
      case (adr)
         ctrl_addr: read_word[4:0] = s.ctrl;
         status_addr: begin
            read_word[stat_state_lsb +: 3] = s.state;
            read_word[stat_ocd_bit] = s.ocd_latched;
            read_word[stat_therm_bit] = s.therm_off;
            read_word[stat_drive_bit] = drive_allow_i;
         end
         irq_status_addr: read_word[irq_width-1:0] = s.irq_status;
         irq_mask_addr: read_word[irq_width-1:0] = s.irq_mask;
         step_count_addr: read_word[15:0] = s.step_count;
         default: read_word = 32'h0000_0000;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      logic src_sw;
      logic step_lvl;
      logic soft_lvl;
      logic dir;
      logic half;
      logic rise;
      logic wr;
      logic [2:0] ev;
      logic drive_on;
      src_sw = 1'b0;
      step_lvl = 1'b0;
      soft_lvl = 1'b0;
      dir = 1'b0;
      half = 1'b0;
      rise = 1'b0;
      wr = 1'b0;
      ev = 3'h0;
      drive_on = 1'b0;
      next_r = r;

      // pick pin or register as the command source
      src_sw = r.ctrl[ctrl_src_bit];
      soft_lvl = r.ctrl[ctrl_step_bit];
      step_lvl = src_sw ? soft_lvl : step_clock_i;
      dir = src_sw ? r.ctrl[ctrl_dir_bit] : rotation_direction_i;
      half = src_sw ? r.ctrl[ctrl_half_bit] : half_select_i;
      next_r.step_prev = step_clock_i;
      next_r.soft_step_prev = soft_lvl;

      rise = src_sw ? (soft_lvl & ~r.soft_step_prev) : (step_lvl & ~r.step_prev);

      if ((src_sw ? r.ctrl[ctrl_reset_bit] : seq_reset_i)) begin
         next_r.state = state_reset_value;
      end else if (rise) begin
         next_r.state = step_next(r.state, half, dir);
         next_r.step_count = r.step_count + 16'h0001;
         ev[irq_step_bit] = 1'b1;
      end

      if (overcurrent_detector_i) begin
         next_r.ocd_latched = 1'b1;
         ev[irq_ocd_bit] = ~r.ocd_latched;
      end else if (!drive_allow_i) begin
         next_r.ocd_latched = r.ocd_latched;
      end else begin
         next_r.ocd_latched = 1'b0;
      end
      // open-drain pull low on fault
      // the pull follows the detector only: holding it while the line reads low
      // would keep the line low for good, since our own pull is what holds it down
      next_r.pull_low = overcurrent_detector_i;

      if (die_temp_i >= therm_trip_c) begin
         next_r.therm_off = 1'b1;
         ev[irq_therm_bit] = ~r.therm_off;
      end else if (die_temp_i <= therm_release_c) begin
         next_r.therm_off = 1'b0;
      end

      // ------------------------------------------------------------------
      // Wishbone classic slave: one wait state, then ack for one cycle
      // ------------------------------------------------------------------
      next_r.ack = 1'b0;
      case (r.bus)
         bus_idle: begin
            if (wb_cyc_i && wb_stb_i) begin
               next_r.bus = bus_ack;
               next_r.ack = 1'b1;
               next_r.dat = read_word(r, wb_adr_i);
               wr = wb_we_i;
            end
         end
         bus_ack: begin
            next_r.bus = bus_idle;
         end
         default: next_r.bus = bus_idle;
      endcase

      // register writes use byte lane 0 only
      if (wr && wb_sel_i[0]) begin
         case (wb_adr_i)
            ctrl_addr: next_r.ctrl = wb_dat_i[4:0];
            irq_mask_addr: next_r.irq_mask = wb_dat_i[irq_width-1:0];
            irq_status_addr: next_r.irq_status = r.irq_status & ~wb_dat_i[irq_width-1:0];
            default: next_r.ctrl = next_r.ctrl;
         endcase
      end
      // set wins over a same-cycle clear
      next_r.irq_status = next_r.irq_status | ev;
      next_r.irq = |(next_r.irq_status & next_r.irq_mask);

      drive_on = drive_allow_i & ~next_r.pull_low & ~next_r.therm_off;
      next_r.phase_a = pif.drive.phase_a;
      next_r.phase_b = pif.drive.phase_b;
      next_r.enable_a = pif.drive.enable_a & drive_on;
      next_r.enable_b = pif.drive.enable_b & drive_on;
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.state <= state_reset_value;
         r.ctrl <= ctrl_reset_value;
         r.irq_mask <= irq_mask_reset_value;
         r.bus <= bus_idle;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign drive_allow_o = 1'b0;      // open drain: only ever pulls low
   assign drive_allow_oe_o = r.pull_low;
   assign phase_a_o = r.phase_a;
   assign enable_a_o = r.enable_a;
   assign phase_b_o = r.phase_b;
   assign enable_b_o = r.enable_b;
   assign irq_o = r.irq;
   assign wb_dat_o = r.dat;
   assign wb_ack_o = r.ack;

endmodule

// ==== stepper_pkg.sv ====
// stepper_pkg: shared constants, register map and types for the stepper phase sequencer
// assumes a 40 MHz single clock and a classic Wishbone register bus
package stepper_pkg;

   // ----------------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] ctrl_addr = 8'h00;
   localparam logic [7:0] status_addr = 8'h04;
   localparam logic [7:0] irq_status_addr = 8'h08;
   localparam logic [7:0] irq_mask_addr = 8'h0C;
   localparam logic [7:0] step_count_addr = 8'h10;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   // control register
   localparam int ctrl_half_bit = 0;
   localparam int ctrl_dir_bit = 1;
   localparam int ctrl_step_bit = 2;
   localparam int ctrl_reset_bit = 3;
   localparam int ctrl_src_bit = 4;
   // status register
   localparam int stat_state_lsb = 0;
   localparam int stat_ocd_bit = 3;
   localparam int stat_therm_bit = 4;
   localparam int stat_drive_bit = 5;
   // interrupt status and mask
   localparam int irq_step_bit = 0;
   localparam int irq_ocd_bit = 1;
   localparam int irq_therm_bit = 2;
   localparam int irq_width = 3;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [4:0] ctrl_reset_value = 5'h01;
   localparam logic [2:0] irq_mask_reset_value = 3'h0;
   localparam logic [2:0] state_reset_value = 3'h0;

   // ----------------------------------------------------------------------
   // temperature thresholds (degrees C, integer sensor code)
   // ----------------------------------------------------------------------
   localparam logic [7:0] therm_trip_c = 8'hA5;
   localparam logic [7:0] therm_hyst_c = 8'h0F;
   localparam logic [7:0] therm_release_c = therm_trip_c - therm_hyst_c;

   // ----------------------------------------------------------------------
   // bus cycle state
   // ----------------------------------------------------------------------
   typedef enum logic [0:0] {
      bus_idle = 1'b0,
      bus_ack = 1'b1
   } bus_state_type;

   // phase outputs for one state: polarity and enable per bridge
   typedef struct packed {
      logic phase_a;
      logic enable_a;
      logic phase_b;
      logic enable_b;
   } drive_type;

endpackage

// ==== phase_if.sv ====
// phase_if: carries the sequencer state and the decoded phase pattern
// assumes one clock domain; the lookup module only decodes combinationally
`timescale 1ns/1ps
interface phase_if;
   import stepper_pkg::*;
   logic [2:0] state;
   drive_type drive;
   modport seq (output state, input drive);
   modport lut (input state, output drive);
endinterface

// ==== phase_lut.sv ====
// phase_lut: fixed table of bridge polarity and enable per sequencer state
// assumes state 0..7 encodes documented states 1..8
`timescale 1ns/1ps
module phase_lut
   import stepper_pkg::*;
(
   phase_if.lut port_i
);

   // ----------------------------------------------------------------------
   // lookup table
   // ----------------------------------------------------------------------
   // fixed phase table
   always_comb begin
      case (port_i.state)
         3'h0: port_i.drive = '{phase_a: 1'b1, enable_a: 1'b1, phase_b: 1'b1, enable_b: 1'b1};
         3'h1: port_i.drive = '{phase_a: 1'b0, enable_a: 1'b0, phase_b: 1'b1, enable_b: 1'b1};
         3'h2: port_i.drive = '{phase_a: 1'b0, enable_a: 1'b1, phase_b: 1'b1, enable_b: 1'b1};
         3'h3: port_i.drive = '{phase_a: 1'b0, enable_a: 1'b1, phase_b: 1'b0, enable_b: 1'b0};
         3'h4: port_i.drive = '{phase_a: 1'b0, enable_a: 1'b1, phase_b: 1'b0, enable_b: 1'b1};
         3'h5: port_i.drive = '{phase_a: 1'b0, enable_a: 1'b0, phase_b: 1'b0, enable_b: 1'b1};
         3'h6: port_i.drive = '{phase_a: 1'b1, enable_a: 1'b1, phase_b: 1'b0, enable_b: 1'b1};
         3'h7: port_i.drive = '{phase_a: 1'b1, enable_a: 1'b1, phase_b: 1'b0, enable_b: 1'b0};
         default: port_i.drive = '{phase_a: 1'b0, enable_a: 1'b0, phase_b: 1'b0, enable_b: 1'b0};
      endcase
   end

endmodule

// ==== stepper_host_model.sv ====
// stepper_host_model: host pins of the sequencer and the pulled-up drive-allow wire
// assumes its tasks are entered just after a rising edge of clk_i
`timescale 1ns/1ps
module stepper_host_model (
   input wire logic clk_i,
   input wire logic pull_low_i,
   output logic step_clock_o,
   output logic rotation_direction_o,
   output logic half_select_o,
   output logic seq_reset_o,
   output logic drive_allow_o
);
   int rc = 0;
   // every host input starts at a firm level
   initial begin
      step_clock_o = 1'b0;
      rotation_direction_o = 1'b1;
      half_select_o = 1'b1;
      seq_reset_o = 1'b0;
   end
   always @(posedge clk_i) begin
      rc <= pull_low_i ? 20 : (rc > 0 ? rc - 1 : 0);
   end
   assign drive_allow_o = !pull_low_i && rc == 0;
   // one step pulse, mode held around it
   task automatic pulse(input logic dir, input logic half);
      rotation_direction_o <= dir;
      half_select_o <= half;
      repeat (2) @(posedge clk_i);
      step_clock_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      step_clock_o <= 1'b0;
      repeat (5) @(posedge clk_i);
   endtask
   task automatic restart(input logic half);
      half_select_o <= half;
      seq_reset_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      seq_reset_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
endmodule

// ==== stepper_phase_sequencer_chk.sv ====
// stepper_phase_sequencer_chk: port-level relations of the sequencer
// assumes the bind below and the package constants
`timescale 1ns/1ps
module stepper_phase_sequencer_chk
   import stepper_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic step_clock_i,
   input wire logic seq_reset_i,
   input wire logic overcurrent_detector_i,
   input wire logic [7:0] die_temp_i,
   input wire logic drive_allow_i,
   input wire logic drive_allow_o,
   input wire logic drive_allow_oe_o,
   input wire logic phase_a_o,
   input wire logic enable_a_o,
   input wire logic phase_b_o,
   input wire logic enable_b_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] pat;
   logic quiet;
   // ----------------------------------------------------------------------
   // bus, stepping and fault relations
   // ----------------------------------------------------------------------
   assign pat = {phase_a_o, enable_a_o, phase_b_o, enable_b_o};
   assign quiet = drive_allow_i && !overcurrent_detector_i && !seq_reset_i
      && die_temp_i <= therm_release_c;
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o) |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack late");
   property p_reset_state; $fell(rst_i) && quiet |=> pat == 4'hF; endproperty
   a_reset_state: assert property (p_reset_state) else $error("not state one");
   property p_step; $rose(step_clock_i) && quiet |-> ##2 pat != $past(pat, 2); endproperty
   a_step: assert property (p_step) else $error("step lost");
   property p_hold; (!$rose(step_clock_i) && quiet) [*6] |-> $stable(pat); endproperty
   a_hold: assert property (p_hold) else $error("moved without step");
   property p_ocd_pull; overcurrent_detector_i |-> ##[1:2] drive_allow_oe_o; endproperty
   a_ocd_pull: assert property (p_ocd_pull) else $error("no pull low");
   property p_od; drive_allow_oe_o |-> !drive_allow_o; endproperty
   a_od: assert property (p_od) else $error("wire driven high");
   property p_gate; !drive_allow_i [*4] |-> !enable_a_o && !enable_b_o; endproperty
   a_gate: assert property (p_gate) else $error("bridges on while disabled");
   property p_therm; (die_temp_i >= therm_trip_c) [*4] |-> !enable_a_o && !enable_b_o;
   endproperty
   a_therm: assert property (p_therm) else $error("bridges on while hot");
   property p_table;
      enable_a_o || enable_b_o |-> pat inside {4'hF, 4'h3, 4'h7, 4'h4, 4'h5, 4'h1, 4'hD, 4'hC};
   endproperty
   a_table: assert property (p_table) else $error("pattern off table");
endmodule
bind stepper_phase_sequencer stepper_phase_sequencer_chk stepper_phase_sequencer_chk_inst (.*);

// ==== test_stepper_phase_sequencer.sv ====
// test_stepper_phase_sequencer: register and pin tests of the sequencer
// assumes the host model for the pins and a pulled-up drive-allow wire
`timescale 1ns/1ps
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module test_stepper_phase_sequencer;
   import stepper_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, overcurrent_detector = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] temp = 8'h19, adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic step, dir, half, sreset, allow, da_o, oe, pa, ea, pb, eb, irq, ack;
   logic [3:0] pats [8] = '{4'hF, 4'h3, 4'h7, 4'h4, 4'h5, 4'h1, 4'hD, 4'hC};
   int mismatches = 0, checks = 0, n;
   always #12.5 clk_i = ~clk_i;
   stepper_host_model stepper_host_model_inst (.clk_i(clk_i), .pull_low_i(oe),
      .step_clock_o(step), .rotation_direction_o(dir), .half_select_o(half),
      .seq_reset_o(sreset), .drive_allow_o(allow));
   stepper_phase_sequencer stepper_phase_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i),
      .step_clock_i(step), .rotation_direction_i(dir), .half_select_i(half),
      .seq_reset_i(sreset), .overcurrent_detector_i(overcurrent_detector), .die_temp_i(temp),
      .drive_allow_i(allow), .drive_allow_o(da_o), .drive_allow_oe_o(oe), .phase_a_o(pa),
      .enable_a_o(ea), .phase_b_o(pb), .enable_b_o(eb), .irq_o(irq), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack));
   // ----------------------------------------------------------------------
   // bus tasks and sequence
   // ----------------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_i);
      end
      if (n >= 50) begin
         mismatches++;
         finish_test();
      end
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHECK(rdat, e)
   endtask
   // state through status and the pins, wire high and cool
   task automatic at(input logic [2:0] s);
      rd(status_addr, {26'h0, 3'h4, s});
      `CHECK({pa, ea, pb, eb}, pats[s])
   endtask
   task automatic finish_test;
      if (mismatches == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(ctrl_addr, 32'h1);
      rd(irq_mask_addr, 32'h0);
      wb(1'b1, 8'h14, 32'hFF);
      rd(8'h14, 32'h0);
      wb(1'b1, ctrl_addr, 32'h1E);
      rd(ctrl_addr, 32'h1E);
      wb(1'b1, ctrl_addr, 32'h1);
      at(3'h0);
      for (int i = 1; i <= 8; i++) begin
         stepper_host_model_inst.pulse(1'b1, 1'b1);
         at(3'(i));
      end
      for (int i = 1; i <= 8; i++) begin
         stepper_host_model_inst.pulse(1'b0, 1'b1);
         at(3'(8 - i));
      end
      `CHECK(irq, 1'b0)
      wb(1'b1, irq_mask_addr, 32'h7);
      rd(irq_status_addr, 32'h1);
      `CHECK(irq, 1'b1)
      wb(1'b1, irq_status_addr, 32'h1);
      rd(irq_status_addr, 32'h0);
      `CHECK(irq, 1'b0)
      rd(step_count_addr, 32'h10);
      stepper_host_model_inst.restart(1'b0);
      at(3'h0);
      for (int i = 1; i <= 8; i++) begin
         stepper_host_model_inst.pulse(i <= 4, 1'b0);
         at(3'(i <= 4 ? 2 * i : 16 - 2 * i));
      end
      stepper_host_model_inst.restart(1'b1);
      stepper_host_model_inst.pulse(1'b1, 1'b1);
      for (int i = 1; i <= 8; i++) begin
         stepper_host_model_inst.pulse(i <= 4, 1'b0);
         at(3'(i <= 4 ? 2 * i + 1 : 17 - 2 * i));
      end
      wb(1'b1, irq_mask_addr, 32'h1);
      overcurrent_detector <= 1'b1;
      repeat (3) @(posedge clk_i);
      overcurrent_detector <= 1'b0;
      `CHECK({oe, da_o, ea, eb}, 4'h8)
      rd(irq_status_addr, 32'h3);
      `CHECK(irq, 1'b1)
      wb(1'b0, status_addr, 32'h0);
      `CHECK(rdat[stat_ocd_bit], 1'b1)
      `CHECK({ea, eb}, 2'h0)
      n = 0;
      while ({ea, eb} === 2'h0 && n < 300) begin
         n++;
         @(posedge clk_i);
      end
      if (n >= 300) begin
         mismatches++;
         finish_test();
      end
      `CHECK({pa, ea, pb, eb}, pats[1])
      wb(1'b1, irq_status_addr, 32'h3);
      temp <= therm_trip_c;
      repeat (6) @(posedge clk_i);
      `CHECK({ea, eb}, 2'h0)
      temp <= therm_release_c + 8'h01;
      repeat (6) @(posedge clk_i);
      rd(status_addr, 32'h31);
      rd(irq_status_addr, 32'h4);
      temp <= therm_release_c;
      repeat (6) @(posedge clk_i);
      at(3'h1);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      at(3'h0);
      rd(irq_status_addr, 32'h0);
      finish_test();
   end
endmodule
